// file: hdl/cdcsr_pkg.sv
/*
 * Constants for the status, result and capacitive setup register block of the
 * two-channel capacitance-to-digital converter.
 * Assumes the serial engine hands over byte-wide register accesses and a stop
 * pulse, all synchronous to the single internal clock.
 */
// Overview of operation
// - status bits 7 to 3 read zero
// - cap done flag low after unread cap result
// - aux done flag low after unread aux result
// - both enabled: combined flag low after both
// - combined flag returns high on read or next
// - one channel enabled: combined follows its flag
// - ready pin follows combined done flag
// - status read-only at pointer zero, reset 0x07
// - cap result loads, locked while being read
// - aux result loads, locked while being read
// - stop condition ends read, lifts lockout
// - cap result is offset binary
// - voltage result is offset binary
// - temperature equals code/2048 minus 4096
// - setup bit 7 enables cap channel
// - setup bit 5 selects differential mode
// - cap setup at pointer seven, reset zero
// - pointer advances per byte until stop
package cdcsr_pkg;
    // ------------------------------------------------------------
    // register pointers
    // ------------------------------------------------------------
    localparam logic [7:0] CDCSR_PTR_STATUS = 8'h00;
    localparam logic [7:0] CDCSR_PTR_CAP_H = 8'h01;
    localparam logic [7:0] CDCSR_PTR_CAP_M = 8'h02;
    localparam logic [7:0] CDCSR_PTR_CAP_L = 8'h03;
    localparam logic [7:0] CDCSR_PTR_AUX_H = 8'h04;
    localparam logic [7:0] CDCSR_PTR_AUX_M = 8'h05;
    localparam logic [7:0] CDCSR_PTR_AUX_L = 8'h06;
    localparam logic [7:0] CDCSR_PTR_CAP_SETUP = 8'h07;
    localparam logic [7:0] CDCSR_PTR_AUX_SETUP = 8'h08;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CDCSR_BIT_CAP_DONE = 0;
    localparam int CDCSR_BIT_AUX_DONE = 1;
    localparam int CDCSR_BIT_ALL_DONE = 2;
    localparam int CDCSR_BIT_CAP_ON = 7;
    localparam int CDCSR_BIT_DIFF = 5;
    localparam int CDCSR_BIT_AUX_ON = 7;
    localparam logic [7:0] CDCSR_STATUS_RST = 8'h07;
    localparam logic [7:0] CDCSR_SETUP_RST = 8'h00;
    localparam logic [23:0] CDCSR_RESULT_RST = 24'h000000;
    // offset binary midpoint, zero scale of cap and voltage results
    localparam logic [23:0] CDCSR_ZERO_SCALE = 24'h800000;
    // temperature: degC = code / 2048 - 4096
    localparam int CDCSR_TEMP_DIV = 2048;
    localparam int CDCSR_TEMP_OFS = 4096;
    localparam int CDCSR_TEMP_SHIFT = 11;
endpackage

// file: hdl/cdcsr_lock.sv
/*
 * Update lockout for one 24-bit result register.
 * Assumes rd_any pulses on every byte read of this register's pointers and
 * stop pulses on the serial stop condition.
 */
module cdcsr_lock
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // serial side
    input wire logic rd_any,
    input wire logic stop,
    // converter side
    input wire logic load,
    input wire logic [23:0] result,
    // stored value
    output logic [23:0] value,
    output logic locked
);
    typedef struct packed {
        logic [23:0] value;
        logic locked;
    } cdcsr_lock_t;

    cdcsr_lock_t s_r;
    cdcsr_lock_t s_nxt;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // a result landing mid-read is dropped, not deferred: keeps bytes coherent
    always_comb
    begin
        s_nxt = s_r;
        if (load && !s_r.locked && !rd_any)
        begin
            s_nxt.value = result;
        end
        if (stop)
        begin
            s_nxt.locked = 1'b0;
        end
        else if (rd_any)
        begin
            s_nxt.locked = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_r <= '{value: cdcsr_pkg::CDCSR_RESULT_RST, locked: 1'b0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign value = s_r.value;
    assign locked = s_r.locked;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_lock_holds_value: assert property (@(posedge clk) disable iff (!resetn)
        s_r.locked && !stop |=> $stable(s_r.value))
        else $error("result changed during read");
    a_stop_unlocks: assert property (@(posedge clk) disable iff (!resetn)
        stop |=> !s_r.locked)
        else $error("lock survived stop");
endmodule

// file: hdl/cdcsr_top.sv
/*
 * Status, result and capacitive setup registers of the converter.
 * Assumes the serial engine gives a start pulse with the pointer, one pulse
 * per byte read or written, and a stop pulse; the analog core gives a one
 * cycle done pulse with a 24-bit result for each channel.
 */
module cdcsr_top
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // serial engine byte port
    input wire logic ser_ptr_load,
    input wire logic [7:0] ser_ptr,
    input wire logic ser_rd,
    input wire logic ser_wr,
    input wire logic [7:0] ser_wdata,
    input wire logic ser_stop,
    output logic [7:0] ser_rdata,
    // converter core
    input wire logic cap_done,
    input wire logic [23:0] cap_result,
    input wire logic aux_done,
    input wire logic [23:0] aux_result,
    input wire logic conv_start,
    // setup outputs and pin
    output logic cap_channel_on,
    output logic differential_select,
    output logic aux_channel_on,
    output logic ready_n
);
    typedef enum logic [1:0] {CDCSR_IDLE, CDCSR_XFER} cdcsr_state_t;

    typedef struct packed {
        cdcsr_state_t state;
        logic [7:0] ptr;
        logic [7:0] rdata;
        logic cap_channel_done_flag;
        logic aux_channel_done_flag;
        logic all_done;
        logic [7:0] cap_setup;
        logic [7:0] aux_setup;
        logic ready_n;
    } cdcsr_top_t;

    cdcsr_top_t s_r;
    cdcsr_top_t s_nxt;

    logic [23:0] cap_value;
    logic [23:0] aux_value;
    logic cap_locked;
    logic aux_locked;
    logic cap_rd;
    logic aux_rd;
    logic [7:0] cur_ptr;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // picks one byte out of a 24-bit result, high byte first
    function automatic logic [7:0] cdcsr_byte(input logic [23:0] v, input logic [1:0] idx);
        logic [7:0] b;
        b = 8'h00;
        case (idx)
            2'h0: b = v[23:16];
            2'h1: b = v[15:8];
            2'h2: b = v[7:0];
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    // the pointer used by this byte: a fresh start takes the new pointer
    assign cur_ptr = ser_ptr_load ? ser_ptr : s_r.ptr;
    assign cap_rd = ser_rd && cur_ptr >= cdcsr_pkg::CDCSR_PTR_CAP_H
        && cur_ptr <= cdcsr_pkg::CDCSR_PTR_CAP_L;
    assign aux_rd = ser_rd && cur_ptr >= cdcsr_pkg::CDCSR_PTR_AUX_H
        && cur_ptr <= cdcsr_pkg::CDCSR_PTR_AUX_L;

    // ------------------------------------------------------------
    // result holders
    // ------------------------------------------------------------
    // results are stored as the core delivers them: offset binary for cap and
    // voltage, code/2048 - 4096 degC for temperature; no recoding here
    cdcsr_lock u_cap_lock
    (
        .clk(clk),
        .resetn(resetn),
        .rd_any(cap_rd),
        .stop(ser_stop),
        .load(cap_done),
        .result(cap_result),
        .value(cap_value),
        .locked(cap_locked)
    );

    cdcsr_lock u_aux_lock
    (
        .clk(clk),
        .resetn(resetn),
        .rd_any(aux_rd),
        .stop(ser_stop),
        .load(aux_done),
        .result(aux_result),
        .value(aux_value),
        .locked(aux_locked)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        // pointer handling and byte read data
        case (s_r.state)
            CDCSR_IDLE:
            begin
                if (ser_ptr_load)
                begin
                    s_nxt.state = CDCSR_XFER;
                end
            end
            CDCSR_XFER:
            begin
                if (ser_stop)
                begin
                    s_nxt.state = CDCSR_IDLE;
                end
            end
            default: s_nxt.state = CDCSR_IDLE;
        endcase
        if (ser_ptr_load)
        begin
            s_nxt.ptr = ser_ptr;
        end
        if (ser_rd || ser_wr)
        begin
            s_nxt.ptr = cur_ptr + 8'h01;
        end
        if (ser_rd)
        begin
            case (cur_ptr)
                cdcsr_pkg::CDCSR_PTR_STATUS:
                    s_nxt.rdata = {5'h00, s_r.all_done, s_r.aux_channel_done_flag,
                        s_r.cap_channel_done_flag};
                cdcsr_pkg::CDCSR_PTR_CAP_H, cdcsr_pkg::CDCSR_PTR_CAP_M,
                cdcsr_pkg::CDCSR_PTR_CAP_L:
                    s_nxt.rdata = cdcsr_byte(cap_value,
                        2'(cur_ptr - cdcsr_pkg::CDCSR_PTR_CAP_H));
                cdcsr_pkg::CDCSR_PTR_AUX_H, cdcsr_pkg::CDCSR_PTR_AUX_M,
                cdcsr_pkg::CDCSR_PTR_AUX_L:
                    s_nxt.rdata = cdcsr_byte(aux_value,
                        2'(cur_ptr - cdcsr_pkg::CDCSR_PTR_AUX_H));
                cdcsr_pkg::CDCSR_PTR_CAP_SETUP: s_nxt.rdata = s_r.cap_setup;
                cdcsr_pkg::CDCSR_PTR_AUX_SETUP: s_nxt.rdata = s_r.aux_setup;
                default: s_nxt.rdata = 8'h00;
            endcase
        end
        // writes: status and results are read-only and ignore writes
        if (ser_wr && cur_ptr == cdcsr_pkg::CDCSR_PTR_CAP_SETUP)
        begin
            s_nxt.cap_setup = ser_wdata;
        end
        if (ser_wr && cur_ptr == cdcsr_pkg::CDCSR_PTR_AUX_SETUP)
        begin
            s_nxt.aux_setup = ser_wdata;
        end
        // per-channel done flags: a result met by a same-cycle read is dropped,
        // so the read wins and the flag goes high
        if (cap_rd)
        begin
            s_nxt.cap_channel_done_flag = 1'b1;
        end
        if (cap_done && !cap_locked && !cap_rd)
        begin
            s_nxt.cap_channel_done_flag = 1'b0;
        end
        if (aux_rd)
        begin
            s_nxt.aux_channel_done_flag = 1'b1;
        end
        if (aux_done && !aux_locked && !aux_rd)
        begin
            s_nxt.aux_channel_done_flag = 1'b0;
        end
        // combined flag
        case ({s_r.cap_setup[cdcsr_pkg::CDCSR_BIT_CAP_ON],
               s_r.aux_setup[cdcsr_pkg::CDCSR_BIT_AUX_ON]})
            2'b11:
            begin
                if (cap_rd || aux_rd || conv_start)
                begin
                    s_nxt.all_done = 1'b1;
                end
                if (!s_nxt.cap_channel_done_flag && !s_nxt.aux_channel_done_flag
                    && (cap_done || aux_done))
                begin
                    s_nxt.all_done = 1'b0;
                end
            end
            2'b10: s_nxt.all_done = s_nxt.cap_channel_done_flag;
            2'b01: s_nxt.all_done = s_nxt.aux_channel_done_flag;
            default: s_nxt.all_done = 1'b1;
        endcase
        s_nxt.ready_n = s_nxt.all_done;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_r <= '{state: CDCSR_IDLE, ptr: 8'h00, rdata: 8'h00,
                cap_channel_done_flag: cdcsr_pkg::CDCSR_STATUS_RST[0],
                aux_channel_done_flag: cdcsr_pkg::CDCSR_STATUS_RST[1],
                all_done: cdcsr_pkg::CDCSR_STATUS_RST[2],
                cap_setup: cdcsr_pkg::CDCSR_SETUP_RST,
                aux_setup: cdcsr_pkg::CDCSR_SETUP_RST,
                ready_n: 1'b1};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flops
    assign ser_rdata = s_r.rdata;
    assign cap_channel_on = s_r.cap_setup[cdcsr_pkg::CDCSR_BIT_CAP_ON];
    assign differential_select = s_r.cap_setup[cdcsr_pkg::CDCSR_BIT_DIFF];
    assign aux_channel_on = s_r.aux_setup[cdcsr_pkg::CDCSR_BIT_AUX_ON];
    assign ready_n = s_r.ready_n;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // pin and combined flag
    a_ready_pin_mirror: assert property (@(posedge clk) disable iff (!resetn)
        ready_n == s_r.all_done)
        else $error("ready pin differs from combined flag");
    a_idle_ready_high: assert property (@(posedge clk) disable iff (!resetn)
        !cap_channel_on && !aux_channel_on |=> s_r.all_done)
        else $error("combined flag low with no channel");
    a_idle_pin_high: assert property (@(posedge clk) disable iff (!resetn)
        !cap_channel_on && !aux_channel_on |=> ready_n)
        else $error("ready pin low with no channel");
    a_cap_only_follow: assert property (@(posedge clk) disable iff (!resetn)
        cap_channel_on && !aux_channel_on |=> s_r.all_done == s_r.cap_channel_done_flag)
        else $error("combined flag not following cap flag");
    a_aux_only_follow: assert property (@(posedge clk) disable iff (!resetn)
        !cap_channel_on && aux_channel_on |=> s_r.all_done == s_r.aux_channel_done_flag)
        else $error("combined flag not following aux flag");

    // both channels enabled: drop needs both, release on read or start
    a_both_need_both: assert property (@(posedge clk) disable iff (!resetn)
        cap_channel_on && aux_channel_on && $fell(s_r.all_done)
        |-> !s_r.cap_channel_done_flag && !s_r.aux_channel_done_flag)
        else $error("combined flag fell early");
    a_both_low_drops: assert property (@(posedge clk) disable iff (!resetn)
        cap_channel_on && aux_channel_on && cap_done && !cap_locked && !cap_rd
        && !s_r.aux_channel_done_flag && !aux_rd |=> !s_r.all_done)
        else $error("combined flag high after both done");
    a_read_clears_all: assert property (@(posedge clk) disable iff (!resetn)
        cap_channel_on && aux_channel_on && cap_rd && !cap_done && !aux_done
        |=> s_r.all_done)
        else $error("combined flag not released by read");
    a_aux_read_clears: assert property (@(posedge clk) disable iff (!resetn)
        cap_channel_on && aux_channel_on && aux_rd && !cap_done && !aux_done |=> s_r.all_done)
        else $error("combined flag not released by aux read");
    a_start_releases_all: assert property (@(posedge clk) disable iff (!resetn)
        cap_channel_on && aux_channel_on && conv_start && !cap_done && !aux_done |=> s_r.all_done)
        else $error("combined flag not released by start");

    // status byte
    a_status_upper_zero: assert property (@(posedge clk) disable iff (!resetn)
        ser_rd && cur_ptr == cdcsr_pkg::CDCSR_PTR_STATUS |=> ser_rdata[7:3] == 5'h00)
        else $error("status upper bits nonzero");
    a_status_flags_read: assert property (@(posedge clk) disable iff (!resetn)
        ser_rd && cur_ptr == cdcsr_pkg::CDCSR_PTR_STATUS |=> ser_rdata[2] == $past(s_r.all_done)
        && ser_rdata[1] == $past(s_r.aux_channel_done_flag)
        && ser_rdata[0] == $past(s_r.cap_channel_done_flag))
        else $error("status byte differs from flags");
    a_status_write_ignored: assert property (@(posedge clk) disable iff (!resetn)
        ser_wr && !ser_rd && !cap_done && !aux_done
        |=> $stable(s_r.cap_channel_done_flag) && $stable(s_r.aux_channel_done_flag))
        else $error("write moved a done flag");

    // pointer
    a_ptr_advance: assert property (@(posedge clk) disable iff (!resetn)
        ser_rd |=> s_r.ptr == $past(cur_ptr) + 8'h01)
        else $error("pointer did not advance");
    a_wr_advance: assert property (@(posedge clk) disable iff (!resetn)
        ser_wr && !ser_rd |=> s_r.ptr == $past(cur_ptr) + 8'h01)
        else $error("pointer did not advance on write");

    // per-channel flags
    a_cap_flag_sets: assert property (@(posedge clk) disable iff (!resetn)
        cap_done && !cap_locked && !cap_rd |=> !s_r.cap_channel_done_flag)
        else $error("cap flag not low after result");
    a_cap_flag_cause: assert property (@(posedge clk) disable iff (!resetn)
        $fell(s_r.cap_channel_done_flag) |-> $past(cap_done) && !$past(cap_locked))
        else $error("cap flag fell without result");
    a_cap_read_releases: assert property (@(posedge clk) disable iff (!resetn)
        cap_rd |=> s_r.cap_channel_done_flag)
        else $error("cap flag not high after read");
    a_aux_flag_sets: assert property (@(posedge clk) disable iff (!resetn)
        aux_done && !aux_locked && !aux_rd |=> !s_r.aux_channel_done_flag)
        else $error("aux flag not low after result");
    a_aux_flag_cause: assert property (@(posedge clk) disable iff (!resetn)
        $fell(s_r.aux_channel_done_flag) |-> $past(aux_done) && !$past(aux_locked))
        else $error("aux flag fell without result");
    a_aux_read_releases: assert property (@(posedge clk) disable iff (!resetn)
        aux_rd |=> s_r.aux_channel_done_flag)
        else $error("aux flag not high after read");

    // lockout: a read locks, a locked result is lost and leaves the flag alone
    a_cap_read_locks: assert property (@(posedge clk) disable iff (!resetn)
        cap_rd && !ser_stop |=> cap_locked)
        else $error("cap read did not lock");
    a_cap_locked_drop: assert property (@(posedge clk) disable iff (!resetn)
        cap_done && cap_locked |=> cap_value == $past(cap_value))
        else $error("locked cap result changed");
    a_cap_drop_no_flag: assert property (@(posedge clk) disable iff (!resetn)
        cap_done && cap_locked && !cap_rd
        |=> s_r.cap_channel_done_flag == $past(s_r.cap_channel_done_flag))
        else $error("dropped cap result moved flag");
    a_cap_high_byte: assert property (@(posedge clk) disable iff (!resetn)
        ser_rd && cur_ptr == cdcsr_pkg::CDCSR_PTR_CAP_H |=> ser_rdata == 8'($past(cap_value) >> 16))
        else $error("cap high byte wrong");
    a_aux_read_locks: assert property (@(posedge clk) disable iff (!resetn)
        aux_rd && !ser_stop |=> aux_locked)
        else $error("aux read did not lock");
    a_aux_locked_drop: assert property (@(posedge clk) disable iff (!resetn)
        aux_done && aux_locked |=> aux_value == $past(aux_value))
        else $error("locked aux result changed");
    a_aux_drop_no_flag: assert property (@(posedge clk) disable iff (!resetn)
        aux_done && aux_locked && !aux_rd
        |=> s_r.aux_channel_done_flag == $past(s_r.aux_channel_done_flag))
        else $error("dropped aux result moved flag");
    a_aux_low_byte: assert property (@(posedge clk) disable iff (!resetn)
        ser_rd && cur_ptr == cdcsr_pkg::CDCSR_PTR_AUX_L |=> ser_rdata == 8'($past(aux_value)))
        else $error("aux low byte wrong");

    // cap setup byte changes only by a write to its pointer
    a_setup_write_lands: assert property (@(posedge clk) disable iff (!resetn)
        ser_wr && cur_ptr == cdcsr_pkg::CDCSR_PTR_CAP_SETUP |=> s_r.cap_setup == $past(ser_wdata))
        else $error("cap setup write lost");
    a_setup_only_write: assert property (@(posedge clk) disable iff (!resetn)
        !(ser_wr && cur_ptr == cdcsr_pkg::CDCSR_PTR_CAP_SETUP) |=> $stable(s_r.cap_setup))
        else $error("cap setup changed without write");
endmodule

// file: sim/cdcsr_host.sv
/*
 * Behavioural serial host driving the byte port of the register block.
 * Assumes strobes are taken on the rising edge and read data is
 * registered one cycle after its strobe.
 */
module cdcsr_host
(
    // clock
    input wire logic clk,
    // byte port towards the block
    output logic ser_ptr_load = 1'b0,
    output logic [7:0] ser_ptr = 8'h00,
    output logic ser_rd = 1'b0,
    output logic ser_wr = 1'b0,
    output logic [7:0] ser_wdata = 8'h00,
    output logic ser_stop = 1'b0,
    input wire logic [7:0] ser_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rbuf [0:15];
    // ------------------------------------------------------------
    // transfers
    // ------------------------------------------------------------
    // burst read, pointer once then n back to back bytes, stop only if asked
    task automatic rd(input logic [7:0] ptr, input int n, input bit stop);
        for (int i = 0; i <= n; i++)
        begin
            if (i > 0)
                rbuf[i - 1] = ser_rdata;
            ser_ptr_load = (i == 0) && (n > 0);
            ser_ptr = (i == 0) ? ptr : ~ser_ptr; // released: no stale value
            ser_rd = (i < n);
            ser_stop = (i == n) && stop;
            @(posedge clk);
            #1;
        end
        ser_stop = 1'b0;
        @(posedge clk);
        #1;
    endtask
    // single byte write, then stop
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        ser_ptr_load = 1'b1;
        ser_ptr = ptr;
        ser_wr = 1'b1;
        ser_wdata = d;
        @(posedge clk);
        #1;
        ser_ptr_load = 1'b0;
        ser_ptr = ~ptr;
        ser_wr = 1'b0;
        ser_wdata = ~d;
        ser_stop = 1'b1;
        @(posedge clk);
        #1;
        ser_stop = 1'b0;
        @(posedge clk);
        #1;
    endtask
endmodule

// file: sim/cdcsr_top_tb.sv
/*
 * Self-checking bench for the status, result and setup register block.
 * Assumes the package, the block and the host model are compiled first.
 */
module cdcsr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ser_ptr_load, ser_rd, ser_wr, ser_stop;
    logic [7:0] ser_ptr, ser_wdata, ser_rdata;
    logic cap_done = 1'b0, aux_done = 1'b0, conv_start = 1'b0;
    logic [23:0] cap_result = 24'h000000, aux_result = 24'h000000;
    logic cap_channel_on, differential_select, aux_channel_on, ready_n;
    int fail_count = 0;
    int n_compared = 0;
    int seed = 32'hEB20FF00;
    logic [23:0] v;
    logic [7:0] d;
    // ------------------------------------------------------------
    // clock, block and host
    // ------------------------------------------------------------
    always #2 clk = ~clk;
    cdcsr_top dut (.clk, .resetn, .ser_ptr_load, .ser_ptr, .ser_rd, .ser_wr,
        .ser_wdata, .ser_stop, .ser_rdata, .cap_done, .cap_result, .aux_done,
        .aux_result, .conv_start, .cap_channel_on, .differential_select,
        .aux_channel_on, .ready_n);
    cdcsr_host host (.clk, .ser_ptr_load, .ser_ptr, .ser_rd, .ser_wr,
        .ser_wdata, .ser_stop, .ser_rdata);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic [7:0] stat(input bit all, input bit aux, input bit cap);
        return {5'h00, all, aux, cap};
    endfunction
    function automatic logic [23:0] temp_code(input int deg);
        return 24'((deg + cdcsr_pkg::CDCSR_TEMP_OFS) * cdcsr_pkg::CDCSR_TEMP_DIV);
    endfunction
    function automatic logic [23:0] got3();
        return {host.rbuf[0], host.rbuf[1], host.rbuf[2]};
    endfunction
    // pin first, then the status byte itself
    task automatic st(input logic [7:0] e);
        chk("ready_n", 24'(ready_n), 24'(e[2]));
        host.rd(8'h00, 1, 1'b1);
        chk("status", 24'(host.rbuf[0]), 24'(e));
    endtask
    // core pulse: 0 cap done, 1 aux done, 2 conversion start
    task automatic done(input int ch, input logic [23:0] r);
        cap_done = (ch == 0);
        aux_done = (ch == 1);
        conv_start = (ch == 2);
        cap_result = r;
        aux_result = r;
        @(posedge clk);
        #1;
        cap_done = 1'b0;
        aux_done = 1'b0;
        conv_start = 1'b0;
        cap_result = ~r; // data not held once the pulse is gone
        aux_result = ~r;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic enable(input logic c, input logic a);
        host.wr(8'h07, {c, 7'h00});
        host.wr(8'h08, {a, 7'h00});
    endtask
    // generous bound, the sequence needs well under a thousand cycles
    initial
    begin
        #40000;
        fail_count++;
        test_done();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk);
        #1;
        resetn = 1'b1;
        // whole map in one burst, including one unmapped pointer
        host.rd(8'h00, 10, 1'b1);
        chk("status", 24'(host.rbuf[0]), 24'(cdcsr_pkg::CDCSR_STATUS_RST));
        for (int i = 1; i < 10; i++)
            chk("reset byte", 24'(host.rbuf[i]), 24'h000000);
        chk("ready_n", 24'(ready_n), 24'h000001);
        $display("test reset done");
        // setup corners then random, status write must not stick
        for (int i = 0; i < 8; i++)
        begin
            d = (i < 4) ? 8'({i[1], 1'b0, i[0], 5'h00}) : 8'($random(seed));
            d = d & 8'hA0;
            host.wr(8'h07, d);
            host.wr(8'h00, ~d);
            host.rd(8'h07, 1, 1'b1);
            chk("cap setup", 24'(host.rbuf[0]), 24'(d));
            chk("cap on", 24'(cap_channel_on), 24'(d[7]));
            chk("diff", 24'(differential_select), 24'(d[5]));
        end
        host.wr(8'h08, 8'h80);
        chk("aux on", 24'(aux_channel_on), 24'h000001);
        st(stat(1, 1, 1));
        $display("test setup done");
        // one channel at a time, codes at scale ends and a temperature
        for (int ch = 0; ch < 2; ch++)
            for (int k = 0; k < 5; k++)
            begin
                v = (k == 0) ? 24'h000000 : (k == 1) ? 24'h800000 : (k == 2) ? 24'hFFFFFF
                    : (k == 3) ? temp_code(-40) : 24'($random(seed));
                enable(ch == 0, ch == 1);
                done(ch, v);
                st(ch ? stat(0, 0, 1) : stat(0, 1, 0));
                host.rd(ch ? 8'h04 : 8'h01, 3, 1'b1);
                chk("result", got3(), v);
                st(stat(1, 1, 1));
            end
        $display("test single channel done");
        // both channels: combined flag waits for both
        enable(1'b1, 1'b1);
        for (int m = 0; m < 2; m++)
        begin
            done(0, 24'h123456);
            st(stat(1, 1, 0));
            done(1, 24'h654321);
            st(stat(0, 0, 0));
            if (m == 0)
                done(2, 24'h000000);
            if (m == 0)
                st(stat(1, 0, 0));
            host.rd(8'h01, 3, 1'b1);
            st(stat(1, 0, 1));
            host.rd(8'h04, 3, 1'b1);
            st(stat(1, 1, 1));
        end
        $display("test both channels done");
        // result arriving mid-read is lost, stop lifts the lockout
        for (int ch = 0; ch < 2; ch++)
        begin
            enable(ch == 0, ch == 1);
            v = 24'($random(seed));
            done(ch, v);
            host.rd(ch ? 8'h04 : 8'h01, 1, 1'b0);
            done(ch, ~v);
            st(stat(1, 1, 1));
            host.rd(ch ? 8'h04 : 8'h01, 3, 1'b1);
            chk("kept", got3(), v);
            done(ch, ~v);
            host.rd(ch ? 8'h04 : 8'h01, 3, 1'b1);
            chk("after stop", got3(), ~v);
        end
        $display("test lockout done");
        // nothing enabled: pin and combined flag stay idle
        enable(1'b0, 1'b0);
        done(0, 24'h0F0F0F);
        st(stat(1, 1, 0));
        $display("test idle done");
        test_done();
    end
endmodule
